/* File: bench/cce_prog_mem.sv */
// program memory model that answers the executor's fetch address
`timescale 1ns/100ps
module cce_prog_mem (
    input  wire logic [cce_pkg::PC_W-1:0]    prog_addr,
    output logic      [cce_pkg::INSTR_W-1:0] prog_data
);
    import cce_pkg::*;

    logic [INSTR_W-1:0] mem [2**PC_W];

    ////////////////////////////////////////////////////////////////////////////////
    // unwritten words hold an unused encoding, so a stray fetch acts as a no-op
    initial begin
        foreach (mem[i]) begin
            mem[i] = 14'h0000;
        end
    end

    // combinational fetch: the word must be settled before the core's tick edge
    assign prog_data = mem[prog_addr];
endmodule // cce_prog_mem

/* File: bench/cpu_call_clear_decrement_exec_tb.sv */
// self-checking bench for the call, clear and decrement executor
`timescale 1ns/100ps
module cpu_call_clear_decrement_exec_tb;
    import cce_pkg::*;

    typedef struct packed {
        logic [13:0] i0;
        logic [13:0] i1;
        logic [4:0]  lat;
        logic [12:0] pc;
        logic [7:0]  w;
        logic [7:0]  f;
        logic        z;
    } cce_row_t;

    logic               pclk    = 1'b0;
    logic               presetn = 1'b0;
    logic               psel    = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite  = 1'b0;
    logic [7:0]         paddr   = 8'h00;
    logic [31:0]        pwdata  = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [INSTR_W-1:0] prog_data;
    logic [PC_W-1:0]    prog_addr;
    logic [31:0]        rd;
    logic               er;
    int                 n_fail      = 0;
    int                 check_count = 0;
    cce_row_t           rows [10];

    always #25 pclk = ~pclk;

    // short watchdog divisors so an overflow shows up within a few dozen ticks
    cce_exec #(.CYCLE_DIV(2), .WDOG_W(2), .PRE_W(2)) cce_exec_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_data(prog_data), .prog_addr(prog_addr)
    );

    cce_prog_mem cce_prog_mem_i (.prog_addr(prog_addr), .prog_data(prog_data));

    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; an idle edge follows so the next setup never collides with the release
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wait_pc(input logic [PC_W-1:0] p);
        int n;
        n = 0;
        while (prog_addr !== p && n < 200) begin
            @(posedge pclk);
            n++;
        end
        // a target never reached is a failure, not a silent return
        if (prog_addr !== p) begin
            n_fail++;
        end
    endtask

    task do_reset;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        end_sim;
    end

    // each row: two instructions, file operand 5 wherever one is used, halts at 2 and 3 are self-calls
    initial begin
        rows = '{
            '{14'h0185, 14'h0000, 5'h00, 13'h0002, 8'h00, 8'h00, 1'b1},
            '{14'h0385, 14'h0000, 5'h00, 13'h0002, 8'h00, 8'hff, 1'b0},
            '{14'h0905, 14'h0000, 5'h00, 13'h0002, 8'h00, 8'hff, 1'b1},
            '{14'h0305, 14'h0100, 5'h00, 13'h0002, 8'h00, 8'hff, 1'b1},
            '{14'h0305, 14'h0985, 5'h00, 13'h0002, 8'hfe, 8'h00, 1'b1},
            '{14'h0100, 14'h0b85, 5'h00, 13'h0002, 8'h00, 8'hff, 1'b1},
            '{14'h0385, 14'h0985, 5'h00, 13'h0002, 8'h00, 8'h01, 1'b0},
            '{14'h0905, 14'h0b05, 5'h00, 13'h0003, 8'h00, 8'h01, 1'b0},
            '{14'h0100, 14'h0b85, 5'h00, 13'h0003, 8'h00, 8'h00, 1'b1},
            '{14'h0100, 14'h27fe, 5'h18, 13'h1ffe, 8'h00, 8'h00, 1'b1}
        };
        foreach (rows[r]) begin
            do_reset;
            cce_prog_mem_i.mem[0] = rows[r].i0;
            cce_prog_mem_i.mem[1] = rows[r].i1;
            cce_prog_mem_i.mem[2] = 14'h2002;
            cce_prog_mem_i.mem[3] = 14'h2003;
            // written after time zero so the memory's own clearing cannot race it
            cce_prog_mem_i.mem[13'h1ffe] = 14'h27fe;
            xfer(REG_PCH, 1'b1, {27'h0, rows[r].lat});
            xfer(REG_FADDR, 1'b1, 32'h5);
            xfer(REG_CTRL, 1'b1, 32'h1);
            wait_pc(rows[r].pc);
            chk("pc", {19'h0, prog_addr}, {19'h0, rows[r].pc});
            xfer(REG_WORK, 1'b0, 32'h0);
            chk("work", rd, {24'h0, rows[r].w});
            xfer(REG_STAT, 1'b0, 32'h0);
            chk("zero", {31'h0, rd[STAT_ZERO]}, {31'h0, rows[r].z});
            xfer(REG_FDATA, 1'b0, 32'h0);
            chk("file", rd, {24'h0, rows[r].f});
            xfer(REG_STACK, 1'b0, 32'h0);
            chk("stack", rd, {19'h0, rows[r].pc + 13'h1});
        end
        // reset state, a read-only write and an unmapped offset
        do_reset;
        xfer(REG_STAT, 1'b0, 32'h0);
        chk("stat_reset", rd, 32'h6);
        xfer(REG_PC, 1'b1, 32'h55);
        xfer(REG_PC, 1'b0, 32'h0);
        chk("pc_read_only", rd, 32'h0);
        xfer(8'h3c, 1'b0, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        // let the watchdog expire, then clear it from a straight run of no-ops
        foreach (rows[i]) begin
            cce_prog_mem_i.mem[i] = 14'h0000;
        end
        cce_prog_mem_i.mem[20] = 14'h0064;
        cce_prog_mem_i.mem[21] = 14'h2015;
        xfer(REG_CTRL, 1'b1, 32'h1);
        wait_pc(13'h0013);
        xfer(REG_STAT, 1'b0, 32'h0);
        chk("timeout_expired", {31'h0, rd[STAT_TO]}, 32'h0);
        wait_pc(13'h0015);
        xfer(REG_STAT, 1'b0, 32'h0);
        chk("timeout_powerdown", {30'h0, rd[STAT_PD:STAT_TO]}, 32'h3);
        xfer(REG_WDOG, 1'b0, 32'h0);
        chk("wdog_count", {24'h0, rd[15:8]}, 32'h0);
        end_sim;
    end
endmodule // cpu_call_clear_decrement_exec_tb

/* File: logic/cce_decode.sv */
// instruction word decoder for the executor
`timescale 1ns/100ps
module cce_decode (
    input  wire logic [cce_pkg::INSTR_W-1:0] instr,
    output cce_pkg::cce_dec_t                dec
);
    import cce_pkg::*;

    // classify one word; other opcodes fall through to a plain advance
    function automatic cce_op_t classify(input logic [INSTR_W-1:0] w);
        if (w[13:11] == CALL_TOP3) begin
            return OP_CALL;
        end else if (w == WDCLR_WORD) begin
            return OP_WDCLR;
        end else if (w[13:7] == CLEAR_FILE_OP_TOP7) begin
            return OP_CLEAR_FILE_OP;
        end else if (w[13:7] == CLEAR_WORKING_OP_TOP7) begin
            return OP_CLEAR_WORKING_OP;
        end else if (w[13:8] == COMPLEMENT_FILE_OP_TOP6) begin
            return OP_COMPLEMENT_FILE_OP;
        end else if (w[13:8] == DECREMENT_FILE_OP_TOP6) begin
            return OP_DECREMENT_FILE_OP;
        end else if (w[13:8] == DECSZ_TOP6) begin
            return OP_DECSZ;
        end
        return OP_NOP;
    endfunction

    // operand fields are plain slices of the word
    always_comb begin
        dec.op      = classify(instr);
        dec.to_file = instr[DEST_BIT];
        dec.faddr   = instr[FADDR_W-1:0];
        dec.target  = instr[LOW_W-1:0];
    end
endmodule // cce_decode

/* File: logic/cce_exec.sv */
// executor for call, watchdog clear, clear, complement and decrement opcodes
`timescale 1ns/100ps
// Summary of operation
// RL1 - a call pushes the current program counter plus one onto the stack top
// RL2 - a call loads its 11-bit operand into program counter bits 10..0
// RL3 - a call fills program counter bits 12..11 from latch bits 4..3
// RL4 - a call lasts two instruction cycles and leaves all flags alone
// RL5 - watchdog clear zeroes counter and prescaler, sets timeout and powerdown flags
// RL6 - clear file writes zero to the addressed register and sets zero flag
// RL7 - clear working writes zero to the working register and sets zero flag
// RL8 - complement inverts the file value; select bit picks working or file
// RL9 - decrement subtracts one, routes by select bit, touches only zero flag
// RL10 - decrement-skip subtracts one and routes result by the select bit
// RL11 - decrement-skip with zero result discards next instruction, taking two cycles
// RL12 - decrement-skip with select zero leaves the file register unmodified
// RL13 - decrement-skip keeps flags; complement and decrement set zero flag on zero
// RL14 - clear, complement, non-skipping decrement take one cycle, counter advances one
module cce_exec #(
    parameter int CYCLE_DIV   = 4,
    parameter int STACK_DEPTH = 8,
    parameter int FILE_DEPTH  = 128,
    parameter int WDOG_W      = 8,
    parameter int PRE_W       = 8
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [cce_pkg::INSTR_W-1:0] prog_data,
    output logic      [cce_pkg::PC_W-1:0]    prog_addr
);
    import cce_pkg::*;

    localparam int DIV_W = (CYCLE_DIV > 1) ? $clog2(CYCLE_DIV) : 1;
    localparam int SP_W  = $clog2(STACK_DEPTH);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLE_DIV - 1);

    logic [DIV_W-1:0]   div_cnt_reg;
    logic               tick_reg;
    logic               run_reg;
    logic [PCH_W-1:0]   pch_reg;
    logic [PC_W-1:0]    pc_reg;
    logic [DATA_W-1:0]  work_reg;
    logic               zero_reg;
    logic               timeout_reg;
    logic               powerdown_reg;
    logic [PRE_W-1:0]   pre_reg;
    logic [WDOG_W-1:0]  wdog_reg;
    logic [SP_W-1:0]    sp_reg;
    logic [PC_W-1:0]    stack_mem [STACK_DEPTH];
    logic [DATA_W-1:0]  file_mem [FILE_DEPTH];
    logic [FADDR_W-1:0] faddr_reg;
    logic [31:0]        prdata_reg;
    logic               pready_reg;
    logic               pslverr_reg;
    cce_state_t         state_reg;
    cce_dec_t           dec;
    logic               go;
    logic               exec_go;
    logic               apb_wr;
    logic [DATA_W-1:0]  src;
    logic [DATA_W-1:0]  result;
    logic               res_zero;
    logic               writes_alu;
    logic [PC_W-1:0]    stack_top;
    logic [31:0]        rd_mux;

    ////////////////////////////////////////////////////////////////////////////////
    // decode and datapath

    cce_decode cce_decode_i (
        .instr (prog_data),
        .dec   (dec)
    );

    // read the operand once; complement and decrement share the result bus
    always_comb begin
        src        = file_mem[dec.faddr];
        result     = (dec.op == OP_COMPLEMENT_FILE_OP) ? ~src : src - 1'b1;
        res_zero   = (result == ZERO_BYTE);
        writes_alu = (dec.op == OP_COMPLEMENT_FILE_OP) || (dec.op == OP_DECREMENT_FILE_OP) || (dec.op == OP_DECSZ);
        stack_top  = stack_mem[sp_reg - 1'b1];
    end

    assign go      = tick_reg && run_reg;
    assign exec_go = go && (state_reg == ST_EXEC);
    assign apb_wr  = psel && penable && pready_reg && pwrite;

    ////////////////////////////////////////////////////////////////////////////////
    // instruction cycle divider

    // one pclk pulse per instruction cycle; all execution is gated by it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= '0;
            tick_reg    <= 1'b0;
        end else begin
            div_cnt_reg <= (div_cnt_reg == DIV_LAST) ? '0 : div_cnt_reg + 1'b1;
            tick_reg    <= (div_cnt_reg == DIV_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencing: program counter, state and return stack

    // flush cycle is a no-operation; the counter was already set for it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_EXEC;
            pc_reg    <= PC_RST;
        end else if (go) begin
            unique case (state_reg)
                ST_EXEC: begin
                    if (dec.op == OP_CALL) begin
                        pc_reg    <= {pch_reg[PCH_HI:PCH_LO], dec.target}; // [RL2] [RL3]
                        state_reg <= ST_FLUSH;                            // [RL4]
                    end else if (dec.op == OP_DECSZ && res_zero) begin
                        pc_reg    <= pc_reg + 2'd2;                        // [RL11]
                        state_reg <= ST_FLUSH;
                    end else begin
                        pc_reg    <= pc_reg + 1'b1;                        // [RL14]
                    end
                end
                ST_FLUSH: begin
                    state_reg <= ST_EXEC;
                end
            endcase
        end
    end

    // circular stack: overflow silently overwrites the oldest entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_reg <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_mem[i] <= PC_RST;
            end
        end else if (exec_go && dec.op == OP_CALL) begin
            stack_mem[sp_reg] <= pc_reg + 1'b1; // [RL1]
            sp_reg            <= sp_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // working register, file registers and zero flag

    // select bit zero keeps the file untouched and lands in working
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_reg <= ZERO_BYTE;
        end else if (exec_go) begin
            if (dec.op == OP_CLEAR_WORKING_OP) begin
                work_reg <= ZERO_BYTE;           // [RL7]
            end else if (writes_alu && !dec.to_file) begin
                work_reg <= result;              // [RL8] [RL9] [RL10] [RL12]
            end
        end
    end

    // file array has no reset, like real ram; software sees it via the window
    always_ff @(posedge pclk) begin
        if (exec_go) begin
            if (dec.op == OP_CLEAR_FILE_OP) begin
                file_mem[dec.faddr] <= ZERO_BYTE; // [RL6]
            end else if (writes_alu && dec.to_file) begin
                file_mem[dec.faddr] <= result;    // [RL8] [RL9] [RL10]
            end
        end
    end

    // decrement-skip and call leave the zero flag alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_reg <= 1'b0;
        end else if (exec_go) begin
            if (dec.op == OP_CLEAR_FILE_OP || dec.op == OP_CLEAR_WORKING_OP) begin
                zero_reg <= 1'b1;                 // [RL6] [RL7]
            end else if (dec.op == OP_COMPLEMENT_FILE_OP || dec.op == OP_DECREMENT_FILE_OP) begin
                zero_reg <= res_zero;             // [RL13]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog counter and its prescaler

    // the clear op outranks an overflow in the same cycle, so the flag is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg       <= '0;
            wdog_reg      <= '0;
            timeout_reg   <= 1'b1;
            powerdown_reg <= 1'b1;
        end else if (exec_go && dec.op == OP_WDCLR) begin
            pre_reg       <= '0;                  // [RL5]
            wdog_reg      <= '0;
            timeout_reg   <= 1'b1;
            powerdown_reg <= 1'b1;
        end else if (tick_reg) begin
            pre_reg <= pre_reg + 1'b1;
            if (&pre_reg) begin
                wdog_reg <= wdog_reg + 1'b1;
                if (&wdog_reg) begin
                    timeout_reg <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, read data latched in the setup cycle

    function automatic logic is_mapped(input logic [7:0] a);
        return a == REG_CTRL || a == REG_STAT || a == REG_PCH || a == REG_PC ||
               a == REG_WORK || a == REG_STACK || a == REG_WDOG ||
               a == REG_FADDR || a == REG_FDATA;
    endfunction

    // read mux; unmapped offsets read zero and flag an error
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            REG_CTRL:  rd_mux[CTRL_RUN] = run_reg;
            REG_STAT:  rd_mux[STAT_FLUSH:STAT_ZERO] =
                           {state_reg == ST_FLUSH, powerdown_reg, timeout_reg, zero_reg};
            REG_PCH:   rd_mux[PCH_W-1:0] = pch_reg;
            REG_PC:    rd_mux[PC_W-1:0] = pc_reg;
            REG_WORK:  rd_mux[DATA_W-1:0] = work_reg;
            REG_STACK: rd_mux[PC_W-1:0] = stack_top;
            REG_WDOG:  begin
                // fields placed separately so narrow widths keep the count at its own offset
                rd_mux[WDOG_CNT_LO +: WDOG_W] = wdog_reg;
                rd_mux[PRE_W-1:0]             = pre_reg;
            end
            REG_FADDR: rd_mux[FADDR_W-1:0] = faddr_reg;
            REG_FDATA: rd_mux[DATA_W-1:0] = file_mem[faddr_reg];
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // pready rises for exactly the access cycle that follows each setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= psel && !penable;
            pslverr_reg <= psel && !penable && !is_mapped(paddr);
            if (psel && !penable && !pwrite) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // software registers steering the core; read-only offsets ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg   <= 1'b0;
            pch_reg   <= PCH_RST;
            faddr_reg <= '0;
        end else if (apb_wr) begin
            unique case (paddr)
                REG_CTRL:  run_reg   <= pwdata[CTRL_RUN];
                REG_PCH:   pch_reg   <= pwdata[PCH_W-1:0];
                REG_FADDR: faddr_reg <= pwdata[FADDR_W-1:0];
                default:   ;
            endcase
        end
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign prog_addr = pc_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_call_push_ret: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        exec_go && dec.op == OP_CALL |=> stack_top == $past(pc_reg) + 1'b1)
        else $error("call pushed wrong return address");

    a_call_low_pc: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        exec_go && dec.op == OP_CALL |=> pc_reg[LOW_W-1:0] == $past(dec.target))
        else $error("call low target bits wrong");

    a_call_high_pc: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
        exec_go && dec.op == OP_CALL |=> pc_reg[PC_W-1:LOW_W] == $past(pch_reg[PCH_HI:PCH_LO]))
        else $error("call high target bits wrong");

    a_call_two_cyc: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        exec_go && dec.op == OP_CALL |=> state_reg == ST_FLUSH && $stable(zero_reg)
        ##[1:CYCLE_DIV] (go && state_reg == ST_FLUSH) ##1 state_reg == ST_EXEC && $stable(pc_reg))
        else $error("call not two cycles or flags moved");

    a_wdog_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
        exec_go && dec.op == OP_WDCLR |=> wdog_reg == '0 && pre_reg == '0 && timeout_reg && powerdown_reg)
        else $error("watchdog clear incomplete");

    a_clear_file: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        exec_go && dec.op == OP_CLEAR_FILE_OP |=> file_mem[$past(dec.faddr)] == ZERO_BYTE && zero_reg)
        else $error("clear file failed");

    a_clear_work: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
        exec_go && dec.op == OP_CLEAR_WORKING_OP |=> work_reg == ZERO_BYTE && zero_reg)
        else $error("clear working failed");

    a_comp_dest: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        exec_go && dec.op == OP_COMPLEMENT_FILE_OP && !dec.to_file |=> work_reg == ~$past(src))
        else $error("complement to working wrong");

    a_dec_dest: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
        exec_go && dec.op == OP_DECREMENT_FILE_OP && dec.to_file
        |=> file_mem[$past(dec.faddr)] == $past(src) - 1'b1 && $stable(work_reg))
        else $error("decrement to file wrong");

    a_dec_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
        exec_go && dec.op == OP_DECREMENT_FILE_OP |=> zero_reg == $past(res_zero))
        else $error("decrement zero flag wrong");

    a_skip_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RL10] [RL12]
        exec_go && dec.op == OP_DECSZ && !dec.to_file
        |=> work_reg == $past(src) - 1'b1 && file_mem[$past(dec.faddr)] == $past(src))
        else $error("decrement-skip routing wrong");

    a_skip_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        exec_go && dec.op == OP_DECSZ |=> (state_reg == ST_FLUSH) == $past(res_zero)
        && pc_reg == $past(pc_reg) + ($past(res_zero) ? 2'd2 : 2'd1))
        else $error("skip decision wrong");

    a_flag_rules: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
        exec_go && (dec.op == OP_DECSZ || dec.op == OP_COMPLEMENT_FILE_OP)
        |=> zero_reg == ($past(dec.op) == OP_DECSZ ? $past(zero_reg) : $past(res_zero)))
        else $error("zero flag handling wrong");

    a_one_cycle: assert property (@(posedge pclk) disable iff (!presetn) // [RL14]
        exec_go && (dec.op == OP_CLEAR_FILE_OP || dec.op == OP_COMPLEMENT_FILE_OP || dec.op == OP_DECREMENT_FILE_OP)
        |=> state_reg == ST_EXEC && pc_reg == $past(pc_reg) + 1'b1)
        else $error("single cycle op did not advance by one");
endmodule // cce_exec

/* File: logic/cce_pkg.sv */
// constants, types and register map of the call/clear/decrement executor
package cce_pkg;
    localparam int PC_W    = 13;
    localparam int LOW_W   = 11;
    localparam int DATA_W  = 8;
    localparam int INSTR_W = 14;
    localparam int FADDR_W = 7;
    localparam int PCH_W   = 5;
    localparam int PCH_LO  = 3;
    localparam int PCH_HI  = 4;
    // opcode fields, matched on the top bits of the instruction word; watchdog clear matches the whole word
    localparam logic [2:0]  CALL_TOP3   = 3'h4;
    localparam logic [13:0] WDCLR_WORD  = 14'h0064;
    localparam logic [6:0]  CLEAR_FILE_OP_TOP7   = 7'h03;
    localparam logic [6:0]  CLEAR_WORKING_OP_TOP7   = 7'h02;
    localparam logic [5:0]  COMPLEMENT_FILE_OP_TOP6   = 6'h09;
    localparam logic [5:0]  DECREMENT_FILE_OP_TOP6   = 6'h03;
    localparam logic [5:0]  DECSZ_TOP6  = 6'h0b;
    localparam int          DEST_BIT    = 7;
    localparam logic [7:0]  ZERO_BYTE   = 8'h00;
    // apb register byte offsets
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STAT    = 8'h04;
    localparam logic [7:0]  REG_PCH     = 8'h08;
    localparam logic [7:0]  REG_PC      = 8'h0c;
    localparam logic [7:0]  REG_WORK    = 8'h10;
    localparam logic [7:0]  REG_STACK   = 8'h14;
    localparam logic [7:0]  REG_WDOG    = 8'h18;
    localparam logic [7:0]  REG_FADDR   = 8'h1c;
    localparam logic [7:0]  REG_FDATA   = 8'h20;
    // status and control bit positions, watchdog count offset and reset values
    localparam int          STAT_ZERO   = 0;
    localparam int          STAT_TO     = 1;
    localparam int          STAT_PD     = 2;
    localparam int          STAT_FLUSH  = 3;
    localparam int          CTRL_RUN    = 0;
    localparam int          WDOG_CNT_LO = 8;
    localparam logic [4:0]  PCH_RST     = 5'h00;
    localparam logic [12:0] PC_RST      = 13'h0000;

    typedef enum logic [2:0] {
        OP_NOP, OP_CALL, OP_WDCLR, OP_CLEAR_FILE_OP, OP_CLEAR_WORKING_OP, OP_COMPLEMENT_FILE_OP, OP_DECREMENT_FILE_OP, OP_DECSZ
    } cce_op_t;

    typedef struct packed {
        cce_op_t              op;
        logic                 to_file;
        logic [FADDR_W-1:0]   faddr;
        logic [LOW_W-1:0]     target;
    } cce_dec_t;

    typedef enum logic [1:0] {
        ST_EXEC  = 2'b01,
        ST_FLUSH = 2'b10
    } cce_state_t;
endpackage
